/* src/apd_pkg.sv */
/*
  Shared constants and types of the converter power-mode link: edge counts
  that choose the power mode, frame length, timing counts and state codes.
  Assumes one system clock of 20 MHz on both ends.
*/
package apd_pkg;

  // data and frame shape
  localparam int         RES_W          = 12;
  localparam int         WORD_W         = 16;
  localparam int         CNT_W          = 5;
  localparam int         SHIFT_W        = 15;
  localparam logic [3:0] LEAD_ZEROS     = 4'h0;
  localparam logic [4:0] FRAME_CLKS     = 5'h10;
  localparam logic [4:0] FRAME_LAST     = 5'h0F;
  localparam logic [4:0] CNT_MAX        = 5'h1F;

  // falling-edge counts: select-rise classes, sampler return to track, sleep burst length
  localparam logic [4:0] PD_FIRST_FALL  = 5'h02;
  localparam logic [4:0] PD_LAST_FALL   = 5'h0A;
  localparam logic [4:0] TRACK_FALLS    = 5'h0D;
  localparam logic [4:0] PD_BURST_FALLS = 5'h04;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_POWER_UP_NS = 1000;
  localparam int T_ACQ_NS      = 225;
  localparam int T_QUIET_NS    = 50;
  localparam int POWER_UP_CYC  =
    (T_POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC       =
    (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_CYC     =
    (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPACE_CYC     = (ACQ_CYC > QUIET_CYC) ? ACQ_CYC : QUIET_CYC;
  localparam int PU_W          = 5;
  localparam int SP_W          = 4;
  localparam logic [PU_W-1:0] POWER_UP_CNT = PU_W'(POWER_UP_CYC);
  localparam logic [SP_W-1:0] SPACE_CNT    = SP_W'(SPACE_CYC - 1);

  // serial clock half period in system cycles, less one
  localparam int         DIV_W    = 3;
  localparam logic [2:0] HALF_CNT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // state codes
  typedef enum logic [2:0] {
    APD_NORMAL = 3'b001,
    APD_DOWN   = 3'b010,
    APD_WAKE   = 3'b100
  } apd_mode_type;

  typedef enum logic [3:0] {
    APD_C_IDLE  = 4'b0001,
    APD_C_SETUP = 4'b0010,
    APD_C_CLOCK = 4'b0100,
    APD_C_QUIET = 4'b1000
  } apd_cstate_type;

  typedef enum logic [1:0] {
    APD_CMD_CONVERT = 2'h0,
    APD_CMD_DUMMY   = 2'h1,
    APD_CMD_SLEEP   = 2'h2
  } apd_cmd_type;

endpackage

/* src/apd_if.sv */
/*
  Link between the converter and its controller: select, serial clock and
  the result line with its enable.
  Assumes the bench joins both ends; a released result line reads as zero.
*/
`timescale 1ns/100ps
interface apd_if;
  logic cs_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  logic serial_result_line;

  // no pull on the line: released reads low
  assign serial_result_line = serial_result_oe & serial_result_out;

  modport dev (
    input  cs_n,
    input  sclk,
    output serial_result_out,
    output serial_result_oe
  );

  modport ctl (
    output cs_n,
    output sclk,
    input  serial_result_line
  );
endinterface

/* src/apd_dev.sv */
/*
  Converter end: samples select and serial clock, counts serial-clock
  falling edges per frame and decides the power mode, drives the result.
  Assumes select and serial clock are asynchronous pins, far slower than
  ref_clk_in; the start-up strap is steady logic on the same clock.
*/
// Functional notes
// [R01] rise in 2..9 falls: power down, abort
// [R02] rise before 2 falls: stay normal
// [R03] wake needs select low past ten falls
// [R04] fully powered after sixteen clocks
// [R05] wake rise before ten falls: back down
// [R06] power-up completes within one microsecond
// [R07] controller keeps quiet time before select falls
// [R08] wake frame: track on first clock edge
// [R09] controller may end dummy after ten falls
// [R10] start-up mode is either, chosen by strap
// [R11] controller may force power-down after start-up
// [R12] controller may send dummy immediately
// [R13] controller allows acquisition before real sample
// [R14] sampler tracks right after start-up
// [R15] power-down pays only at low throughput
// [R16] normal mode: select low ten falls
// [R17] select fall: hold, sample, start, drive
// [R18] full result needs sixteen clocks here
// [R19] count falls, classify rise at two, ten
`timescale 1ns/100ps
module apd_dev (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  // link
  apd_if.dev                             link,
  // user side
  input  wire logic [apd_pkg::RES_W-1:0] analog_input,
  input  wire logic                      startup_down_in,
  output logic      [apd_pkg::RES_W-1:0] sample_out,
  output logic                           powered_out,
  output logic                           power_down_out,
  output logic                           waking_out,
  output logic                           tracking_out,
  output logic                           dummy_frame_out,
  output logic                           aborted_out
);
  import apd_pkg::*;

  logic              cs_meta;
  logic              cs_sync;
  logic              cs_prev;
  logic              sclk_meta;
  logic              sclk_sync;
  logic              sclk_prev;
  logic              cs_fall;
  logic              cs_rise;
  logic              sclk_fall;
  logic              sclk_rise;
  logic              in_frame;
  logic [CNT_W-1:0]  fall_cnt;
  logic [WORD_W-1:0] shreg;
  logic              drive;
  logic              strap_taken;
  logic [PU_W-1:0]   pu_cnt;
  logic              pu_done;
  logic              track;
  apd_mode_type      mode;
  apd_mode_type      next_mode;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_prev   <= 1'b1;
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      cs_meta   <= link.cs_n;
      cs_sync   <= cs_meta;
      cs_prev   <= cs_sync;
      sclk_meta <= link.sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  assign cs_fall   = cs_prev & ~cs_sync;
  assign cs_rise   = ~cs_prev & cs_sync;
  // clock edges outside a frame are ignored
  assign sclk_fall = sclk_prev & ~sclk_sync & ~cs_sync;
  assign sclk_rise = ~sclk_prev & sclk_sync & ~cs_sync;

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking and falling-edge count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      in_frame <= 1'b0;
    end else if (cs_fall) begin
      in_frame <= 1'b1;
    end else if (cs_rise) begin
      in_frame <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fall_cnt <= '0;
    end else if (cs_fall) begin
      fall_cnt <= '0; // see [R19]
    end else if (sclk_fall && fall_cnt != CNT_MAX) begin
      fall_cnt <= fall_cnt + 5'h01; // see [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode
  always_comb begin
    next_mode = mode;
    case (mode)
      APD_NORMAL: begin
        // glitch below two falls keeps the part awake
        if (cs_rise && fall_cnt >= PD_FIRST_FALL
            && fall_cnt < PD_LAST_FALL) begin
          next_mode = APD_DOWN; // see [R01] [R02] [R19]
        end
      end
      APD_DOWN: begin
        if (cs_fall) begin
          next_mode = APD_WAKE; // see [R03]
        end
      end
      APD_WAKE: begin
        if (cs_rise && in_frame && fall_cnt < PD_LAST_FALL) begin
          next_mode = APD_DOWN; // see [R05] [R03]
        end else if (in_frame && fall_cnt == FRAME_CLKS) begin
          next_mode = APD_NORMAL; // see [R04]
        end else if (pu_done && fall_cnt >= PD_LAST_FALL) begin
          next_mode = APD_NORMAL; // see [R06]
        end
      end
      default: begin
        next_mode = APD_NORMAL;
      end
    endcase
  end

  // strap is read on the first cycle after release, never under reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode <= APD_NORMAL;
    end else if (!strap_taken) begin
      mode <= startup_down_in ? APD_DOWN : APD_NORMAL; // see [R10]
    end else begin
      mode <= next_mode;
    end
  end

  // power-up timer runs on from select fall, even after select rises at ten falls or more
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || mode != APD_WAKE) begin
      pu_cnt <= '0;
    end else if (!pu_done) begin
      pu_cnt <= pu_cnt + 5'h01; // see [R06]
    end
  end

  assign pu_done = (pu_cnt >= POWER_UP_CNT);

  ////////////////////////////////////////////////////////////////////////////
  // sampler: hold from select fall, back to track later
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      track <= 1'b1; // see [R14]
    end else if (cs_fall) begin
      track <= 1'b0; // see [R17]
    end else if (mode != APD_DOWN && next_mode == APD_DOWN) begin
      track <= 1'b0;
    end else if (mode == APD_WAKE && in_frame
                 && (sclk_fall || sclk_rise)) begin
      track <= 1'b1; // see [R08]
    end else if (sclk_rise && fall_cnt >= TRACK_FALLS) begin
      track <= 1'b1;
    end else if (cs_rise && mode == APD_NORMAL
                 && next_mode == APD_NORMAL) begin
      track <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result shifter and line drive
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      shreg      <= '0;
      sample_out <= '0;
    end else if (cs_fall) begin
      shreg      <= {LEAD_ZEROS, analog_input}; // see [R17]
      sample_out <= analog_input;
    end else if (sclk_fall && in_frame) begin
      shreg <= {shreg[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      drive <= 1'b0;
    end else if (cs_fall) begin
      drive <= 1'b1; // see [R17]
    end else if (cs_rise) begin
      drive <= 1'b0; // see [R01]
    end else if (sclk_fall && fall_cnt == FRAME_LAST) begin
      drive <= 1'b0; // see [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dummy_frame_out <= 1'b0;
      aborted_out     <= 1'b0;
    end else begin
      if (cs_fall) begin
        dummy_frame_out <= (mode != APD_NORMAL); // see [R04]
      end
      aborted_out <= cs_rise && in_frame && fall_cnt < FRAME_CLKS;
    end
  end

  assign link.serial_result_out = shreg[WORD_W-1];
  assign link.serial_result_oe  = drive;
  assign powered_out            = mode[0];
  assign power_down_out         = mode[1];
  assign waking_out             = mode[2];
  assign tracking_out           = track;

endmodule

/* src/apd_ctl.sv */
/*
  Controller end: makes select and the serial clock, runs conversion,
  dummy and power-down frames, collects the result.
  Assumes the converter end on the far side of the link.
*/
`timescale 1ns/100ps
module apd_ctl (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  // link
  apd_if.ctl                             link,
  // command
  input  wire logic                      cmd_valid_in,
  input  wire apd_pkg::apd_cmd_type      cmd_in,
  output logic                           cmd_ready_out,
  // result
  output logic      [apd_pkg::RES_W-1:0] result_out,
  output logic                           result_valid_out,
  output logic                           busy_out
);
  import apd_pkg::*;

  apd_cstate_type     state;
  apd_cmd_type        cmd;
  logic [DIV_W-1:0]   div_cnt;
  logic               tick;
  logic [CNT_W-1:0]   falls;
  logic [CNT_W-1:0]   target;
  logic [SP_W-1:0]    space_cnt;
  logic [SHIFT_W-1:0] shift;
  logic               data_meta;
  logic               data_sync;
  logic               cs_n;
  logic               sclk;

  // result line comes from outside this domain
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      data_meta <= link.serial_result_line;
      data_sync <= data_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-period divider
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state == APD_C_IDLE || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign tick = (div_cnt == HALF_CNT);

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state     <= APD_C_IDLE;
      cmd       <= APD_CMD_CONVERT;
      cs_n      <= 1'b1;
      sclk      <= 1'b1;
      falls     <= '0;
      target    <= FRAME_CLKS;
      space_cnt <= '0;
    end else begin
      case (state)
        APD_C_IDLE: begin
          if (cmd_valid_in) begin
            cmd   <= cmd_in;
            cs_n  <= 1'b0;
            falls <= '0;
            // four falls lands inside the power-down window
            target <= (cmd_in == APD_CMD_SLEEP) ? PD_BURST_FALLS
                                                : FRAME_CLKS;
            state <= APD_C_SETUP;
          end
        end
        APD_C_SETUP: begin
          if (tick) begin
            sclk  <= 1'b0;
            falls <= 5'h01;
            state <= APD_C_CLOCK;
          end
        end
        APD_C_CLOCK: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
            if (falls == target) begin
              cs_n      <= 1'b1; // see [R16] [R09] [R11]
              space_cnt <= '0;
              state     <= APD_C_QUIET;
            end
          end else if (tick) begin
            sclk  <= 1'b0;
            falls <= falls + 5'h01;
          end
        end
        APD_C_QUIET: begin
          // spacing covers quiet time and acquisition
          if (space_cnt == SPACE_CNT) begin
            state <= APD_C_IDLE; // see [R07] [R13]
          end else begin
            space_cnt <= space_cnt + 4'h1;
          end
        end
        default: begin
          state <= APD_C_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture on rising serial clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      shift            <= '0;
      result_out       <= '0;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= 1'b0;
      if (state == APD_C_CLOCK && tick && !sclk) begin
        if (falls < FRAME_CLKS) begin
          shift <= {shift[SHIFT_W-2:0], data_sync};
        end
        if (falls == target && cmd == APD_CMD_CONVERT) begin
          result_out       <= shift[RES_W-1:0]; // see [R18]
          result_valid_out <= 1'b1;
        end
      end
    end
  end

  assign link.cs_n     = cs_n;
  assign link.sclk     = sclk;
  assign cmd_ready_out = (state == APD_C_IDLE);
  assign busy_out      = (state != APD_C_IDLE);

endmodule

/* tb/apd_chk.sv */
/*
  Checker of the controller-converter link: select and serial clock shape,
  and the timing of the result line and its enable.
  Assumes both ends on one clock, reset synchronous and active high.
*/
`timescale 1ns/100ps
module apd_chk (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic serial_result_line
);
  import apd_pkg::*;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // serial clock falls since select fell, saturating
  logic [CNT_W-1:0] nfall;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cs_n) begin
      nfall <= 5'h00;
    end else if ($fell(sclk) && nfall != CNT_MAX) begin
      nfall <= nfall + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_lead;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_low_half;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence s_oe_drop;
    ##2 serial_result_oe ##1 !serial_result_oe;
  endsequence

  a_first_fall: assert property ($fell(cs_n) |-> s_lead)
    else $error("first clock fall off time");
  a_half_period: assert property ($fell(sclk) |-> s_low_half)
    else $error("clock low phase wrong");
  a_oe_after_fall: assert property (
    $fell(cs_n) |-> ##3 serial_result_oe)
    else $error("result not driven after select fall");
  a_lead_zero: assert property ($fell(cs_n) |-> ##3
    (serial_result_oe && !serial_result_out && !serial_result_line) [*8])
    else $error("leading zeros missing");
  a_oe_follows_cs: assert property (
    serial_result_oe |-> !$past(cs_n, 3))
    else $error("result driven without select");
  a_oe_off_rise: assert property (
    $rose(cs_n) |-> ##3 !serial_result_oe)
    else $error("result not released after select rise");
  a_oe_ends_16th: assert property (
    ($fell(sclk) && nfall == FRAME_LAST) |-> s_oe_drop)
    else $error("result not released after last fall");
  a_frame_len: assert property ($rose(cs_n) |->
    (nfall == FRAME_CLKS || nfall == PD_BURST_FALLS))
    else $error("frame fall count wrong");
  a_sclk_rests: assert property (cs_n |-> sclk)
    else $error("serial clock moves outside frame");
  a_quiet_gap: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("quiet time too short");
endmodule

/* tb/tb_adc_power_down_control.sv */
/*
  Bench of the power-mode link: a controller and converter pair, and a
  second converter whose select and clock the bench drives itself.
  Assumes package, interface and both ends are compiled before it.
*/
`timescale 1ns/100ps
module tb_adc_power_down_control;
  import apd_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             cmd_valid_in = 1'b0;
  apd_cmd_type      cmd_in = APD_CMD_CONVERT;
  logic [RES_W-1:0] analog_input = 12'h000;
  logic             cmd_ready_out;
  logic             result_valid_out;
  logic [RES_W-1:0] result_out;
  logic [RES_W-1:0] sample_out;
  wire logic [2:0]  mode_a;
  wire logic [2:0]  mode_b;
  logic             busy;
  logic             track_a;
  logic             track_b;
  logic             dummy_a;
  logic             abort_a;
  int               n_fail = 0;
  int               compares = 0;
  int               n_abort = 0;
  int               abort_base = 0;

  apd_if link1 ();
  apd_if link2 ();

  apd_ctl apd_ctl_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link1),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .result_out(result_out),
    .result_valid_out(result_valid_out), .busy_out(busy));
  // strap: this end starts powered down, the second one normal
  apd_dev apd_dev_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link1),
    .analog_input(analog_input), .startup_down_in(1'b1),
    .sample_out(sample_out), .powered_out(mode_a[0]),
    .power_down_out(mode_a[1]), .waking_out(mode_a[2]),
    .tracking_out(track_a), .dummy_frame_out(dummy_a),
    .aborted_out(abort_a));
  apd_dev apd_dev_x_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .link(link2), .analog_input(analog_input), .startup_down_in(1'b0),
    .sample_out(), .powered_out(mode_b[0]), .power_down_out(mode_b[1]),
    .waking_out(mode_b[2]), .tracking_out(track_b), .dummy_frame_out(),
    .aborted_out());
  apd_chk apd_chk_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cs_n(link1.cs_n), .sclk(link1.sclk),
    .serial_result_out(link1.serial_result_out),
    .serial_result_oe(link1.serial_result_oe),
    .serial_result_line(link1.serial_result_line));

  always #25 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (abort_a === 1'b1) n_abort++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  // reads happen at the edge, so they see values before its updates
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready_out !== 1'b1 && k < 600) begin
      cyc(1);
      k++;
    end
    if (k >= 600) n_fail++;
  endtask

  task automatic send(input apd_cmd_type c);
    wait_ready();
    cmd_in <= c;
    cmd_valid_in <= 1'b1;
    cyc(1);
    cmd_valid_in <= 1'b0;
    cyc(1);
  endtask

  // bench-made link clock, 400 ns: four system cycles each half
  task automatic frame2(input int n);
    link2.cs_n <= 1'b0;
    cyc(4);
    repeat (n) begin
      link2.sclk <= 1'b0;
      cyc(4);
      link2.sclk <= 1'b1;
      cyc(4);
    end
    link2.cs_n <= 1'b1;
    cyc(12);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    check(mode_a, APD_DOWN);
    check(mode_b, APD_NORMAL);
    check(track_a, 1'b1);
    check(track_b, 1'b1);
  endtask

  task automatic t_wake();
    send(APD_CMD_DUMMY);
    cyc(5);
    check(busy, 1'b1);
    check(track_a, 1'b0);
    check(mode_a, APD_WAKE);
    cyc(8);
    check(track_a, 1'b1);
    cyc(136);
    check(mode_a, APD_WAKE);
    cyc(7);
    check(mode_a, APD_NORMAL);
    wait_ready();
    check(dummy_a, 1'b1);
  endtask

  task automatic t_convert();
    logic [RES_W-1:0] v [2] = '{12'hA5C, 12'h5A3};
    int k;
    abort_base = n_abort;
    foreach (v[i]) begin
      analog_input <= v[i];
      send(APD_CMD_CONVERT);
      k = 0;
      while (result_valid_out !== 1'b1 && k < 400) begin
        cyc(1);
        k++;
      end
      if (k >= 400) n_fail++;
      check(result_out, v[i]);
      check(sample_out, v[i]);
      check(mode_a, APD_NORMAL);
      check(track_a, 1'b1);
      check(dummy_a, 1'b0);
    end
  endtask

  // sleep only between widely spaced conversions
  task automatic t_sleep();
    send(APD_CMD_SLEEP);
    wait_ready();
    check(mode_a, APD_DOWN);
    check(track_a, 1'b0);
    check(n_abort - abort_base, 1);
    check(link1.serial_result_oe, 1'b0);
  endtask

  task automatic t_window();
    int n [9] = '{0, 1, 2, 8, 9, 10, 9, 16, 10};
    apd_mode_type m [9] = '{APD_NORMAL, APD_NORMAL, APD_DOWN, APD_DOWN,
      APD_DOWN, APD_NORMAL, APD_DOWN, APD_NORMAL, APD_NORMAL};
    for (int i = 0; i < 9; i++) begin
      frame2(n[i]);
      check(mode_b, m[i]);
      check(link2.serial_result_oe, 1'b0);
    end
  endtask

  initial begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b1;
    cyc(16);
    rst_in <= 1'b0;
    cyc(3);
    t_start();
    t_wake();
    t_convert();
    t_sleep();
    t_wake();
    t_window();
    stop_test();
  end

  initial begin
    cyc(20000);
    n_fail++;
    stop_test();
  end
endmodule
